// ---- irm_pkg.sv ----
package irm_pkg;

    // ------------
    // Register map (Modbus holding register addresses)
    // ------------
    localparam logic [15:0] ADDR_CMD_NUM   = 16'h044F;  // Command number
    localparam logic [15:0] ADDR_CHAN_SEL  = 16'h0450;  // Channel mask
    localparam logic [15:0] ADDR_CH1_TRIG  = 16'h0455;  // Channel one trigger
    localparam logic [15:0] ADDR_CH2_TRIG  = 16'h0457;  // Channel two trigger

    // ------------
    // Value ranges
    // ------------
    localparam logic [15:0] CMD_MIN        = 16'h0001;
    localparam logic [15:0] CMD_MAX        = 16'h0200;  // 512
    localparam logic [15:0] CHAN_MIN       = 16'h0001;
    localparam logic [15:0] CHAN_MAX       = 16'h0003;
    localparam logic [15:0] TRIG_MAX       = 16'h00E0;  // 224
    localparam logic [15:0] QTY_MAX        = 16'h007B;  // 123 words per write

    // ------------
    // Protocol constants
    // ------------
    localparam logic [15:0] MB_PORT        = 16'h01F6;  // 502
    localparam logic [7:0]  FC_WR_SINGLE   = 8'h06;
    localparam logic [7:0]  FC_WR_MULTI    = 8'h10;
    localparam logic [7:0]  FC_EXC_FLAG    = 8'h80;
    localparam logic [7:0]  EXC_NONE       = 8'h00;
    localparam logic [7:0]  EXC_FUNCTION   = 8'h01;
    localparam logic [7:0]  EXC_ADDRESS    = 8'h02;
    localparam logic [7:0]  EXC_VALUE      = 8'h03;

    // Byte positions inside a request, unit id at zero
    localparam logic [7:0]  POS_FC         = 8'h01;
    localparam logic [7:0]  POS_ADDR_HI    = 8'h02;
    localparam logic [7:0]  POS_ADDR_LO    = 8'h03;
    localparam logic [7:0]  POS_W4         = 8'h04;
    localparam logic [7:0]  POS_W5         = 8'h05;
    localparam logic [7:0]  POS_BCNT       = 8'h06;
    localparam logic [7:0]  POS_DATA       = 8'h07;
    localparam logic [7:0]  POS_MAX        = 8'hFF;

    // Response lengths
    localparam logic [2:0]  RESP_LEN_OK    = 3'h6;
    localparam logic [2:0]  RESP_LEN_EXC   = 3'h3;

    // Reset values
    localparam logic [15:0] RST_WORD       = 16'h0000;
    localparam logic [7:0]  RST_BYTE       = 8'h00;

    // Channel masks
    localparam logic [1:0]  CHAN_ONE       = 2'h1;
    localparam logic [1:0]  CHAN_TWO       = 2'h2;

    // ------------
    // Types
    // ------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RECV = 4'h2,
        ST_DROP = 4'h4,
        ST_EMIT = 4'h8
    } irm_state_e;

    // Request toward the playback engine
    typedef struct packed {
        logic [1:0]  chan;   // Bit 0 channel one, bit 1 channel two
        logic [15:0] cmd;    // Stored command number
    } irm_emit_s;

    // Answer bytes, byte 0 goes out first
    typedef struct packed {
        logic [2:0]      len;
        logic [5:0][7:0] bytes;
    } irm_resp_s;

    // Which register a word hits
    typedef struct packed {
        logic cmd;
        logic chan;
        logic t1;
        logic t2;
    } irm_hit_s;

    typedef struct packed {
        irm_state_e  st;
        logic [7:0]  idx;
        logic [7:0]  unit;
        logic [7:0]  fc;
        logic [15:0] addr;
        logic [15:0] qty;
        logic [7:0]  bcnt;
        logic [7:0]  hi;
        logic [7:0]  wk;
        logic [7:0]  err;
        logic [15:0] sh_cmd;
        logic [15:0] sh_chan;
        logic [15:0] sh_t1;
        logic [15:0] sh_t2;
        irm_hit_s    wr;
        logic [15:0] cmd_reg;
        logic [15:0] chan_reg;
        logic [15:0] t1_reg;
        logic [15:0] t2_reg;
        logic [2:0]  pend;
        logic        emit_vld;
        irm_emit_s   emit;
        logic        resp_go;
        irm_resp_s   resp;
    } irm_core_s;

    typedef struct packed {
        logic [2:0]      rem;
        logic [5:0][7:0] sh;
    } irm_tx_s;

endpackage

// ---- irm_reg_check.sv ----
`timescale 1ns/10ps

// ------------
// Address decode and value range check for one written word
// ------------
module irm_reg_check
    import irm_pkg::*;
(
    // Word under test
    input  wire logic [15:0] word_addr_i,
    input  wire logic [15:0] word_val_i,
    // Result
    output irm_hit_s         hit_o,
    output logic             val_ok_o
);

    // Decode the four mapped holding registers
    always_comb
    begin
        hit_o.cmd  = (word_addr_i == ADDR_CMD_NUM);
        hit_o.chan = (word_addr_i == ADDR_CHAN_SEL);
        hit_o.t1   = (word_addr_i == ADDR_CH1_TRIG);
        hit_o.t2   = (word_addr_i == ADDR_CH2_TRIG);
    end

    // Range of each register, zero is never a legal value
    always_comb
    begin
        if (hit_o.cmd)
        begin
            val_ok_o = (word_val_i >= CMD_MIN) && (word_val_i <= CMD_MAX);   // see [R4]
        end
        else if (hit_o.chan)
        begin
            val_ok_o = (word_val_i >= CHAN_MIN) && (word_val_i <= CHAN_MAX); // see [R5]
        end
        else if (hit_o.t1 || hit_o.t2)
        begin
            val_ok_o = (word_val_i >= CMD_MIN) && (word_val_i <= TRIG_MAX);  // see [R7]
        end
        else
        begin
            val_ok_o = 1'b0;
        end
    end

endmodule

// ---- irm_resp_tx.sv ----
`timescale 1ns/10ps

// ------------
// Answer serialiser: shifts out up to six bytes
// ------------
module irm_resp_tx
    import irm_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       nrst_i,
    // Load side
    input  wire logic       start_i,
    input  irm_resp_s       resp_i,
    output logic            busy_o,
    // Byte stream toward the transport
    output logic [7:0]      tx_data_o,
    output logic            tx_valid_o,
    output logic            tx_last_o,
    input  wire logic       tx_ready_i
);

    irm_tx_s s_reg;   // Remaining count and shift register
    irm_tx_s s_next;

    // Handshake outputs straight off the count
    assign busy_o     = (s_reg.rem != 3'h0);
    assign tx_valid_o = busy_o;
    assign tx_last_o  = (s_reg.rem == 3'h1);
    assign tx_data_o  = s_reg.sh[0];

    // Load on start, shift on each accepted byte
    always_comb
    begin
        s_next = s_reg;
        if (start_i && !busy_o)
        begin
            s_next.rem = resp_i.len;
            s_next.sh  = resp_i.bytes;
        end
        else if (busy_o && tx_ready_i)
        begin
            s_next.rem = s_reg.rem - 3'h1;
            s_next.sh  = {RST_BYTE, s_reg.sh[5:1]};
        end
    end

    // State register
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

endmodule

// ---- irm_front_end.sv ----
`timescale 1ns/10ps

// How it works
// [R1] Only function codes 6 and 16 write
// [R2] Words arrive high byte then low byte
// [R3] Requests accepted on port 502, TCP or UDP
// [R4] Command number register, values 1 to 512
// [R5] Channel select register, values 1 to 3
// [R6] Bit 0 channel one, bit 1 channel two
// [R7] Channel one trigger emits at once, 1-224
// [R8] Channel two trigger emits at once, 1-224
// [R9] Two-word multi write sets both, then emits
// [R10] Client writes number first, then channel select
// [R11] Bad values emit nothing, answer exception 03
module irm_front_end
    import irm_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    // Request bytes from the transport, unit id first
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        rx_valid_i,
    input  wire logic        rx_first_i,
    input  wire logic        rx_last_i,
    input  wire logic [15:0] rx_port_i,
    output logic             rx_ready_o,
    // Answer bytes toward the transport
    output logic [7:0]       tx_data_o,
    output logic             tx_valid_o,
    output logic             tx_last_o,
    input  wire logic        tx_ready_i,
    // Emit request toward the playback engine
    output irm_emit_s        emit_o,
    output logic             emit_valid_o,
    input  wire logic        emit_ready_i,
    // Register contents
    output logic [15:0]      cmd_num_o,
    output logic [15:0]      chan_sel_o
);

    // ------------
    // Declarations
    // ------------
    irm_core_s   s_reg;       // Whole state of the block
    irm_core_s   s_next;      // Its next value
    irm_hit_s    chk_hit;     // Register hit of current word
    logic        chk_ok;      // Value in range
    logic [15:0] chk_addr;    // Address of current word
    logic [15:0] chk_val;     // Value of current word
    logic        tx_busy;     // Answer still going out
    logic        take;        // Byte accepted this cycle
    logic        fc_known;    // Function is a write we support
    logic        is_single;   // Single-register write
    logic        word_done;   // Low byte of a word arrives now
    logic [7:0]  err_w;       // Error after this byte
    logic [7:0]  fin_err;     // Error at end of frame
    logic        len_ok;      // Frame length matches its header
    logic [7:0]  data_pos;    // Offset inside multi-write data

    // ------------
    // Helpers
    // ------------
    assign take       = rx_valid_i && rx_ready_o;
    assign is_single  = (s_reg.fc == FC_WR_SINGLE);
    assign fc_known   = is_single || (s_reg.fc == FC_WR_MULTI);   // see [R1]
    assign data_pos   = s_reg.idx - POS_DATA;

    // Word address steps by one for each word of a multi write
    assign chk_addr   = s_reg.addr + {8'h00, s_reg.wk};
    assign chk_val    = {s_reg.hi, rx_data_i};                    // see [R2]

    // Low byte of a word: position 5 for code 6, odd data offset for 16
    always_comb
    begin
        if (!fc_known || s_reg.st != ST_RECV)
        begin
            word_done = 1'b0;
        end
        else if (is_single)
        begin
            word_done = (s_reg.idx == POS_W5);
        end
        else
        begin
            word_done = (s_reg.idx >= POS_DATA) && data_pos[0];
        end
    end

    // Address errors come before value errors; first fault sticks
    always_comb
    begin
        err_w = s_reg.err;
        if (word_done && s_reg.err == EXC_NONE)
        begin
            if (chk_hit == '0)
            begin
                err_w = EXC_ADDRESS;
            end
            else if (!chk_ok)
            begin
                err_w = EXC_VALUE;                                  // see [R11]
            end
        end
    end

    // Length check: header, quantity and byte count must agree
    always_comb
    begin
        if (is_single)
        begin
            len_ok = (s_reg.idx == POS_W5);
        end
        else
        begin
            len_ok = (s_reg.idx >= POS_DATA)
                  && ((s_reg.idx - POS_BCNT) == s_reg.bcnt)
                  && ({s_reg.qty[6:0], 1'b0} == s_reg.bcnt)
                  && (s_reg.qty != 16'h0000)
                  && (s_reg.qty <= QTY_MAX);                        // see [R9]
        end
    end

    // Unknown function outranks length, length outranks the rest
    assign fin_err = !fc_known ? EXC_FUNCTION :
                     !len_ok   ? EXC_VALUE    : err_w;

    // ------------
    // Submodules
    // ------------
    irm_reg_check u_check (
        .word_addr_i (chk_addr),
        .word_val_i  (chk_val),
        .hit_o       (chk_hit),
        .val_ok_o    (chk_ok)
    );

    irm_resp_tx u_tx (
        .ref_clk_i   (ref_clk_i),
        .nrst_i      (nrst_i),
        .start_i     (s_reg.resp_go),
        .resp_i      (s_reg.resp),
        .busy_o      (tx_busy),
        .tx_data_o   (tx_data_o),
        .tx_valid_o  (tx_valid_o),
        .tx_last_o   (tx_last_o),
        .tx_ready_i  (tx_ready_i)
    );

    // ------------
    // Outputs
    // ------------
    // New frames wait while an answer or an emit is still out
    assign rx_ready_o   = (s_reg.st != ST_EMIT);
    assign emit_o       = s_reg.emit;
    assign emit_valid_o = s_reg.emit_vld;
    assign cmd_num_o    = s_reg.cmd_reg;
    assign chan_sel_o   = s_reg.chan_reg;

    // ------------
    // Next state
    // ------------
    always_comb
    begin
        s_next         = s_reg;
        s_next.resp_go = 1'b0;

        // Emit handshake: drop valid once taken
        if (s_reg.emit_vld && emit_ready_i)
        begin
            s_next.emit_vld = 1'b0;
        end

        unique case (s_reg.st)
            // Wait for the start of a frame
            ST_IDLE:
            begin
                if (take && rx_first_i && !rx_last_i)
                begin
                    s_next.unit = rx_data_i;
                    s_next.idx  = POS_FC;
                    s_next.err  = EXC_NONE;
                    s_next.wk   = RST_BYTE;
                    s_next.wr   = '0;
                    // Only the port matters, not the transport
                    s_next.st   = (rx_port_i == MB_PORT) ? ST_RECV : ST_DROP; // see [R3]
                end
            end

            // Collect header and data bytes
            ST_RECV:
            begin
                if (take)
                begin
                    if (s_reg.idx != POS_MAX)
                    begin
                        s_next.idx = s_reg.idx + 8'h01;
                    end
                    s_next.err = err_w;
                    case (s_reg.idx)
                        POS_FC:      s_next.fc         = rx_data_i;
                        POS_ADDR_HI: s_next.addr[15:8] = rx_data_i;
                        POS_ADDR_LO: s_next.addr[7:0]  = rx_data_i;
                        POS_W4:
                        begin
                            s_next.hi        = rx_data_i;             // see [R2]
                            s_next.qty[15:8] = rx_data_i;
                        end
                        POS_W5:      s_next.qty[7:0]   = rx_data_i;
                        POS_BCNT:    s_next.bcnt       = rx_data_i;
                        default:
                        begin
                            // Even data offset carries a high byte
                            if (!data_pos[0])
                            begin
                                s_next.hi = rx_data_i;
                            end
                        end
                    endcase

                    // Park every word that hits a register, in range or not, until the frame is whole
                    if (word_done)
                    begin
                        s_next.wk = s_reg.wk + 8'h01;
                        if (chk_hit.cmd)
                        begin
                            s_next.sh_cmd = chk_val;                  // see [R4]
                            s_next.wr.cmd = 1'b1;
                        end
                        if (chk_hit.chan)
                        begin
                            s_next.sh_chan = chk_val;                 // see [R5]
                            s_next.wr.chan = 1'b1;
                        end
                        if (chk_hit.t1)
                        begin
                            s_next.sh_t1 = chk_val;
                            s_next.wr.t1 = 1'b1;
                        end
                        if (chk_hit.t2)
                        begin
                            s_next.sh_t2 = chk_val;
                            s_next.wr.t2 = 1'b1;
                        end
                    end

                    // End of frame: commit or refuse, then answer
                    if (rx_last_i)
                    begin
                        s_next.resp_go = 1'b1;
                        s_next.st      = ST_EMIT;
                        if (fin_err == EXC_NONE)
                        begin
                            // Shadow values already include this last word
                            if (s_next.wr.cmd)
                            begin
                                s_next.cmd_reg = s_next.sh_cmd;
                            end
                            if (s_next.wr.chan)
                            begin
                                s_next.chan_reg = s_next.sh_chan;
                            end
                            if (s_next.wr.t1)
                            begin
                                s_next.t1_reg = s_next.sh_t1;
                            end
                            if (s_next.wr.t2)
                            begin
                                s_next.t2_reg = s_next.sh_t2;
                            end
                            // Channel select write is what fires the shared emit
                            s_next.pend = {s_next.wr.t2, s_next.wr.t1,
                                           s_next.wr.chan};           // see [R10]
                            s_next.resp.len = RESP_LEN_OK;
                            s_next.resp.bytes = {is_single ? rx_data_i : s_reg.qty[7:0],
                                                 is_single ? s_reg.hi : s_reg.qty[15:8],
                                                 s_reg.addr[7:0], s_reg.addr[15:8],
                                                 s_reg.fc, s_reg.unit};
                        end
                        else
                        begin
                            // Refused frame: registers keep their old values
                            s_next.pend       = 3'h0;                 // see [R11]
                            s_next.resp.len   = RESP_LEN_EXC;
                            s_next.resp.bytes = {RST_BYTE, RST_BYTE, RST_BYTE, fin_err,
                                                 s_reg.fc | FC_EXC_FLAG, s_reg.unit};
                        end
                    end
                end
            end

            // Frame for another port: swallow silently
            ST_DROP:
            begin
                if (take && rx_last_i)
                begin
                    s_next.st = ST_IDLE;
                end
            end

            // Hand out emits one at a time, wait for the answer to leave
            ST_EMIT:
            begin
                if (!s_reg.emit_vld || emit_ready_i)
                begin
                    if (s_reg.pend[0])
                    begin
                        s_next.emit_vld  = 1'b1;
                        s_next.emit.cmd  = s_reg.cmd_reg;             // see [R9]
                        s_next.emit.chan = s_reg.chan_reg[1:0];       // see [R6]
                        s_next.pend[0]   = 1'b0;
                    end
                    else if (s_reg.pend[1])
                    begin
                        s_next.emit_vld  = 1'b1;
                        s_next.emit.cmd  = s_reg.t1_reg;
                        s_next.emit.chan = CHAN_ONE;                  // see [R7]
                        s_next.pend[1]   = 1'b0;
                    end
                    else if (s_reg.pend[2])
                    begin
                        s_next.emit_vld  = 1'b1;
                        s_next.emit.cmd  = s_reg.t2_reg;
                        s_next.emit.chan = CHAN_TWO;                  // see [R8]
                        s_next.pend[2]   = 1'b0;
                    end
                    else if (!tx_busy && !s_reg.resp_go)
                    begin
                        s_next.st = ST_IDLE;
                    end
                end
            end
        endcase
    end

    // ------------
    // State register
    // ------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            s_reg          <= '0;
            s_reg.st       <= ST_IDLE;
            s_reg.cmd_reg  <= RST_WORD;
            s_reg.chan_reg <= RST_WORD;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

endmodule

// ---- irm_front_end_properties.sv ----
`timescale 1ns/10ps
// ------------
// Port checker
// ------------
module irm_front_end_properties
    import irm_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    // Streams
    input  wire logic        rx_ready_o,
    input  wire logic [7:0]  tx_data_o,
    input  wire logic        tx_valid_o,
    input  wire logic        tx_last_o,
    input  wire logic        tx_ready_i,
    // Emit and registers
    input  irm_emit_s        emit_o,
    input  wire logic        emit_valid_o,
    input  wire logic        emit_ready_i,
    input  wire logic [15:0] cmd_num_o,
    input  wire logic [15:0] chan_sel_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    // Offers that the far side has not yet taken
    sequence s_emit_wait;
        emit_valid_o && !emit_ready_i;
    endsequence
    sequence s_tx_wait;
        tx_valid_o && !tx_ready_i;
    endsequence
    a_emit_held: assert property (s_emit_wait |=> emit_valid_o && $stable(emit_o))
        else $error("emit request changed while stalled");
    a_tx_held: assert property (s_tx_wait
        |=> tx_valid_o && $stable({tx_data_o, tx_last_o}))
        else $error("answer byte changed while stalled");
    a_last_ends: assert property (tx_valid_o && tx_ready_i
        |=> tx_valid_o != $past(tx_last_o))
        else $error("last answer byte flag misplaced");
    a_emit_cmd_range: assert property (emit_valid_o
        |-> emit_o.cmd inside {[CMD_MIN:CMD_MAX]})
        else $error("emit command out of range");
    a_emit_chan_nonzero: assert property (emit_valid_o |-> emit_o.chan != 2'h0)
        else $error("emit with no channel");
    a_cmd_update: assert property (!$stable(cmd_num_o)
        |-> cmd_num_o inside {[CMD_MIN:CMD_MAX]})
        else $error("command register took a bad value");
    a_chan_update: assert property (!$stable(chan_sel_o)
        |-> chan_sel_o inside {[CHAN_MIN:CHAN_MAX]})
        else $error("channel register took a bad value");
    a_both_emit: assert property ($rose(emit_valid_o) && emit_o.chan == 2'h3
        |-> chan_sel_o == 16'h0003 && emit_o.cmd == cmd_num_o)
        else $error("dual channel emit does not match registers");
    a_busy_no_rx: assert property (emit_valid_o || tx_valid_o |-> !rx_ready_o)
        else $error("request taken while busy");
    a_reset_idle: assert property ($rose(nrst_i) |-> rx_ready_o && !tx_valid_o && !emit_valid_o)
        else $error("not idle after reset");
endmodule

bind irm_front_end irm_front_end_properties u_irm_front_end_properties (.ref_clk_i, .nrst_i,
    .rx_ready_o, .tx_data_o, .tx_valid_o, .tx_last_o, .tx_ready_i, .emit_o, .emit_valid_o,
    .emit_ready_i, .cmd_num_o, .chan_sel_o);

// ---- irm_client_model.sv ----
`timescale 1ns/10ps
// ------------
// Client model: request sender and answer sink
// ------------
module irm_client_model
    import irm_pkg::*;
(
    // Clock
    input  wire logic        clk_i,
    // Request stream
    output logic [7:0]       rx_data_o,
    output logic             rx_valid_o,
    output logic             rx_first_o,
    output logic             rx_last_o,
    output logic [15:0]      rx_port_o,
    input  wire logic        rx_ready_i,
    // Answer stream
    input  wire logic [7:0]  tx_data_i,
    input  wire logic        tx_valid_i,
    output logic             tx_ready_o
);
    logic [7:0] ans[$];  // Answer bytes collected
    initial
    begin
        {rx_data_o, rx_valid_o, rx_first_o, rx_last_o, rx_port_o} = '0;
        tx_ready_o = 1'b0;
    end
    // Sink stalls every other cycle
    always @(posedge clk_i)
    begin
        tx_ready_o <= ~tx_ready_o;
        if (tx_valid_i && tx_ready_o)
            ans.push_back(tx_data_i);
    end
    // Whole frame, held per byte until taken; call just after a rising edge
    task automatic send(input logic [7:0] req[$], input logic [15:0] port);
        logic ok;
        for (int i = 0; i < req.size(); i++)
        begin
            rx_data_o  <= req[i];
            rx_valid_o <= 1'b1;
            rx_first_o <= (i == 0);
            rx_last_o  <= (i == req.size() - 1);
            rx_port_o  <= port;
            do
            begin
                @(negedge clk_i);
                ok = rx_ready_i;
                @(posedge clk_i);
            end while (!ok);
        end
        // Released line shows no stale byte
        rx_valid_o <= 1'b0;
        rx_data_o  <= ~req[req.size() - 1];
    endtask
endmodule

// ---- irm_front_end_tb.sv ----
`timescale 1ns/10ps
// ------------
// Front end bench
// ------------
module irm_front_end_tb;
    import irm_pkg::*;
    logic ref_clk_i, nrst_i, rx_valid_i, rx_first_i, rx_last_i, rx_ready_o;
    logic tx_valid_o, tx_last_o, tx_ready_i, emit_valid_o, emit_ready_i = 1'b0;
    logic [7:0]  rx_data_i, tx_data_o;
    logic [15:0] rx_port_i, cmd_num_o, chan_sel_o;
    irm_emit_s   emit_o;
    irm_emit_s   emits[$];   // Emits taken by the engine
    int          failures, n_checks, cyc = 0;
    irm_front_end u_irm_front_end (.*);
    irm_client_model u_irm_client_model (.clk_i(ref_clk_i), .rx_data_o(rx_data_i),
        .rx_valid_o(rx_valid_i), .rx_first_o(rx_first_i), .rx_last_o(rx_last_i),
        .rx_port_o(rx_port_i), .rx_ready_i(rx_ready_o), .tx_data_i(tx_data_o),
        .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i));
    initial
    begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    // Engine stalls every other cycle; hang guard
    always @(posedge ref_clk_i)
    begin
        emit_ready_i <= ~emit_ready_i;
        if (emit_valid_o && emit_ready_i)
            emits.push_back(emit_o);
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            failures++;
            final_report();
        end
    end
    task automatic chk_val(input logic [17:0] got, input logic [17:0] exp);
        n_checks++;
        if (got !== exp)
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        if (got !== exp)
            failures++;
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        chk_val({10'h000, got}, {10'h000, exp});
    endtask
    // One frame; emit_exp of zero means no emit
    task automatic xfer(input logic [7:0] req[$], input logic [15:0] port,
                        input logic [7:0] exp[$], input logic [17:0] emit_exp);
        int k;
        u_irm_client_model.ans.delete();
        emits.delete();
        u_irm_client_model.send(req, port);
        @(negedge ref_clk_i);
        for (k = 0; k < 300 && !rx_ready_o; k++)
            @(negedge ref_clk_i);
        chk_val(k < 300, 18'h1);
        @(posedge ref_clk_i);
        chk_val(u_irm_client_model.ans.size(), exp.size());
        foreach (exp[i])
            chk_byte(u_irm_client_model.ans[i], exp[i]);
        chk_val(emits.size(), emit_exp != 0);
        if (emits.size() > 0)
            chk_val(emits[0], emit_exp);
    endtask
    task automatic w6(input logic [15:0] a, input logic [15:0] v, input logic ok,
                      input logic [17:0] emit_exp);
        logic [7:0] q[$];
        q = '{8'h01, FC_WR_SINGLE, a[15:8], a[7:0], v[15:8], v[7:0]};
        if (ok)
            xfer(q, MB_PORT, q, emit_exp);
        else
            xfer(q, MB_PORT, '{8'h01, FC_WR_SINGLE | FC_EXC_FLAG, EXC_VALUE}, 18'h0);
    endtask
    task automatic final_report();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        {nrst_i, failures, n_checks} = '0;
        repeat (2) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        @(posedge ref_clk_i);
        chk_val(cmd_num_o, RST_WORD);
        w6(ADDR_CMD_NUM, 16'h0001, 1'b1, 18'h0);
        w6(ADDR_CHAN_SEL, 16'h0003, 1'b1, {2'h3, 16'h0001});
        w6(ADDR_CHAN_SEL, 16'h0001, 1'b1, {CHAN_ONE, 16'h0001});
        w6(ADDR_CH1_TRIG, TRIG_MAX, 1'b1, {CHAN_ONE, TRIG_MAX});
        w6(ADDR_CH2_TRIG, 16'h0001, 1'b1, {CHAN_TWO, 16'h0001});
        w6(ADDR_CH2_TRIG, 16'h00E1, 1'b0, 18'h0);
        w6(ADDR_CHAN_SEL, 16'h0004, 1'b0, 18'h0);
        w6(ADDR_CMD_NUM, 16'h0201, 1'b0, 18'h0);
        w6(ADDR_CMD_NUM, 16'h0000, 1'b0, 18'h0);
        xfer('{8'h01, 8'h06, 8'h04, 8'h51, 8'h00, 8'h01}, MB_PORT,
             '{8'h01, 8'h86, EXC_ADDRESS}, 18'h0);
        chk_val(cmd_num_o, 16'h0001);
        xfer('{8'h01, 8'h10, 8'h04, 8'h4F, 8'h00, 8'h02, 8'h04, 8'h02, 8'h00, 8'h00, 8'h02},
             MB_PORT, '{8'h01, 8'h10, 8'h04, 8'h4F, 8'h00, 8'h02}, {CHAN_TWO, CMD_MAX});
        chk_val(chan_sel_o, 16'h0002);
        xfer('{8'h01, 8'h03, 8'h04, 8'h4F, 8'h00, 8'h01}, MB_PORT,
             '{8'h01, 8'h83, EXC_FUNCTION}, 18'h0);
        xfer('{8'h01, 8'h06, 8'h04, 8'h4F, 8'h00, 8'h05}, 16'h01F7, '{}, 18'h0);
        chk_val(cmd_num_o, CMD_MAX);
        final_report();
    end
endmodule
